// [hw/line_unit_silo.v]
/*
 * Transmit silo load/unload sequencing, receive silo, and the transmit and
 * receive control/status registers of a synchronous line unit.
 * Assumes all strobes come from logic on clk as single-cycle pulses, and
 * that the processor reads status through the two status output buses.
 */
`timescale 1ns/100ps
`default_nettype none
`include "line_unit_defines.vh"

// Behaviour
// - Transmit select strobe sets the load latch
// - Accepted character clears load latch, moves down
// - Transmitter load pulse sets the unload latch
// - Output-ready drop clears unload latch, data kept
// - Control bits 0-3 queued in silo bits 8-11
// - Bit 0 begin, bit 1 finish, all write-only
// - Queued begin/finish gated by output-ready
// - Transmit bit 4 shows silo input-ready
// - Transmit bit 6 active, cleared by clear
// - Bit 7 or device clear pulses transmit clear
// - Bit 5 of both registers reserved, zero
// - Receive bits 0-3 come from silo output
// - Match flag: zero or residue per mode
// - Block end needs flag plus mode condition
// - Block end also reports received abort
// - Receive bit 4 shows silo output-ready
// - Receive bit 6 from receiver active sync
// - Bit 7 or device clear pulses receive clear
// - Both silos 64 deep, 12 wide
// - Receive clear empties the receive silo
// - Read-accepted pops only while output-ready
module line_unit_silo #(
	parameter SILO_DEPTH = `SILO_DEPTH,
	parameter SILO_AW = 6,
	parameter CLEAR_CYCLES = `CLEAR_CYCLES
) (
	// Clock, reset, enable
	input wire clk,
	input wire rst,
	input wire ce,
	// Processor output bus and register selects
	input wire [7:0] obus,
	input wire sel_tx_data,
	input wire sel_tx_ctl,
	input wire sel_rx_ctl,
	input wire device_clear,
	input wire rx_read_accepted,
	// Processor read side
	output wire [7:0] tx_ctl_status,
	output wire [7:0] rx_ctl_status,
	output wire [7:0] rx_data,
	// Transmitter side
	input wire tx_load,
	input wire tx_clk_tick,
	input wire tx_decoder_active,
	output reg [7:0] tx_char,
	output wire tx_queue_has_data,
	output wire tx_message_begin,
	output wire tx_message_finish,
	output wire transmit_clear_pulse,
	output wire transmit_clear_pulse_n,
	// Receiver side
	input wire rx_char_strobe,
	input wire [7:0] rx_char,
	input wire [15:0] rx_check,
	input wire bit_stuff_mode,
	input wire primary_mode,
	input wire flag_received,
	input wire message_active,
	input wire addr_sync_received,
	input wire abort_received,
	input wire rx_ctl_tick,
	input wire rx_decoder_active,
	output wire rx_input_ready,
	output wire receive_clear_pulse,
	output wire receive_clear_pulse_n
);

	// ======================================================================
	// Declarations
	reg [3:0] tx_ctl_bits_r;
	reg [7:0] tx_hold_r;
	reg [3:0] tx_hold_ctl_r;
	reg tx_load_latch_r;
	reg tx_unload_latch_r;
	reg tx_active_latch_r;
	reg [7:0] tx_clr_cnt_r;
	reg [7:0] rx_clr_cnt_r;
	reg [7:0] rdr_data_r;
	reg rdr_match_r;
	reg rdr_block_end_r;
	reg rdr_valid_r;
	reg rx_active_r;
	wire tx_clear_fire;
	wire rx_clear_fire;
	wire tx_in_ready;
	wire tx_out_valid;
	wire [`SILO_WIDTH-1:0] tx_head;
	wire tx_push;
	wire tx_pop;
	wire rx_out_valid;
	wire [`SILO_WIDTH-1:0] rx_head;
	wire rx_push_ready;
	wire check_char_match;
	wire block_end;
	wire queued_message_begin;
	wire queued_message_finish;

	// ======================================================================
	// Clear pulse generation
	// Either a clear bit written as one or a device clear starts the pulse
	assign tx_clear_fire = device_clear |
		(sel_tx_ctl & obus[`TXCS_CLEAR]);
	assign rx_clear_fire = device_clear |
		(sel_rx_ctl & obus[`RXCS_CLEAR]);

	// Counters stand in for the one-shots; a retrigger restarts the width
	always @(posedge clk) begin
		if (rst) begin
			tx_clr_cnt_r <= 8'h00;
			rx_clr_cnt_r <= 8'h00;
		end else if (ce) begin
			if (tx_clear_fire)
				tx_clr_cnt_r <= CLEAR_CYCLES[7:0];
			else if (tx_clr_cnt_r != 8'h00)
				tx_clr_cnt_r <= tx_clr_cnt_r - 8'h01;
			if (rx_clear_fire)
				rx_clr_cnt_r <= CLEAR_CYCLES[7:0];
			else if (rx_clr_cnt_r != 8'h00)
				rx_clr_cnt_r <= rx_clr_cnt_r - 8'h01;
		end
	end

	// Complementary pair, as the far logic expects both senses
	assign transmit_clear_pulse = (tx_clr_cnt_r != 8'h00);
	assign transmit_clear_pulse_n = ~transmit_clear_pulse;
	assign receive_clear_pulse = (rx_clr_cnt_r != 8'h00);
	assign receive_clear_pulse_n = ~receive_clear_pulse;

	// ======================================================================
	// Transmit control bits and character holding register
	// Control bits are only written here; no read path exists for them
	always @(posedge clk) begin
		if (rst) begin
			tx_ctl_bits_r <= 4'h0;
		end else if (ce && sel_tx_ctl) begin
			tx_ctl_bits_r <= obus[`TXCS_CTL_MSB:`TXCS_CTL_LSB];
		end
	end

	// The select captures the character so it stands while the latch is up
	always @(posedge clk) begin
		if (rst) begin
			tx_hold_r <= 8'h00;
			tx_hold_ctl_r <= 4'h0;
		end else if (ce && sel_tx_data) begin
			tx_hold_r <= obus;
			tx_hold_ctl_r <= tx_ctl_bits_r;
		end
	end

	// ======================================================================
	// Load latch
	// Set on the select strobe; dropped once input-ready falls, that is on
	// acceptance or when the silo is already full. A set in the same cycle
	// as a drop wins so a back-to-back select is not lost; the transmit clear pulse beats both.
	assign tx_push = tx_load_latch_r & tx_in_ready;

	always @(posedge clk) begin
		if (rst || (ce && transmit_clear_pulse)) begin
			tx_load_latch_r <= 1'b0;
		end else if (ce) begin
			if (sel_tx_data)
				tx_load_latch_r <= 1'b1;
			else if (tx_push || !tx_in_ready)
				tx_load_latch_r <= 1'b0;
		end
	end

	// ======================================================================
	// Transmit silo
	silo_fifo #(
		.WIDTH(`SILO_WIDTH),
		.DEPTH(SILO_DEPTH),
		.AW(SILO_AW)
	) tx_silo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.flush(transmit_clear_pulse),
		.in_valid(tx_load_latch_r),
		.in_ready(tx_in_ready),
		.in_data({tx_hold_ctl_r, tx_hold_r}),
		.out_valid(tx_out_valid),
		.out_ready(tx_unload_latch_r),
		.out_data(tx_head)
	);

	// ======================================================================
	// Unload latch
	// Set by the transmitter load pulse, dropped when output-ready falls
	assign tx_pop = tx_unload_latch_r & tx_out_valid;

	always @(posedge clk) begin
		if (rst || (ce && transmit_clear_pulse)) begin
			tx_unload_latch_r <= 1'b0;
		end else if (ce) begin
			if (tx_load)
				tx_unload_latch_r <= 1'b1;
			else if (tx_pop || !tx_out_valid)
				tx_unload_latch_r <= 1'b0;
		end
	end

	// Unloaded character stays presented when the silo runs empty
	always @(posedge clk) begin
		if (rst) begin
			tx_char <= 8'h00;
		end else if (ce && tx_pop) begin
			tx_char <= tx_head[`SILO_DATA_BITS-1:0];
		end
	end

	// ======================================================================
	// Queued message flags to the transmitter control
	assign queued_message_begin = tx_head[`SILO_CTL_LSB + `TXCS_MSG_BEGIN];
	assign queued_message_finish = tx_head[`SILO_CTL_LSB + `TXCS_MSG_FINISH];
	assign tx_message_begin = queued_message_begin & tx_out_valid;
	assign tx_message_finish = queued_message_finish & tx_out_valid;
	assign tx_queue_has_data = tx_out_valid;

	// ======================================================================
	// Transmitter active flag
	// Sampled on the transmit clock tick; the clear pulse overrides it
	always @(posedge clk) begin
		if (rst || (ce && transmit_clear_pulse)) begin
			tx_active_latch_r <= 1'b0;
		end else if (ce && tx_clk_tick) begin
			tx_active_latch_r <= tx_decoder_active;
		end
	end

	// ======================================================================
	// Receive flags
	// Residue differs by protocol: zero for byte count, fixed for bit stuff
	assign check_char_match = bit_stuff_mode ?
		(rx_check == `CHECK_RESIDUE) : (rx_check == `CHECK_ZERO);

	// Abort shares the block end bit so software sees both the same way
	assign block_end = (flag_received &
		(primary_mode ? message_active : addr_sync_received)) |
		abort_received;

	// ======================================================================
	// Receive data register
	// Holds one character with its flags until the silo takes it. A new
	// strobe while one is still pending overwrites it; the receiver is
	// expected to watch rx_input_ready.
	assign rx_push_ready = rdr_valid_r;

	always @(posedge clk) begin
		if (rst || (ce && receive_clear_pulse)) begin
			rdr_valid_r <= 1'b0;
			rdr_data_r <= 8'h00;
			rdr_match_r <= 1'b0;
			rdr_block_end_r <= 1'b0;
		end else if (ce) begin
			if (rx_char_strobe) begin
				rdr_valid_r <= 1'b1;
				rdr_data_r <= rx_char;
				rdr_match_r <= check_char_match;
				rdr_block_end_r <= block_end;
			end else if (rx_input_ready) begin
				rdr_valid_r <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Receive silo
	// Clear flushes every entry, not just the head
	silo_fifo #(
		.WIDTH(`SILO_WIDTH),
		.DEPTH(SILO_DEPTH),
		.AW(SILO_AW)
	) rx_silo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.flush(receive_clear_pulse),
		.in_valid(rx_push_ready),
		.in_ready(rx_input_ready),
		.in_data({2'b00, rdr_block_end_r, rdr_match_r, rdr_data_r}),
		.out_valid(rx_out_valid),
		.out_ready(rx_read_accepted),
		.out_data(rx_head)
	);

	assign rx_data = rx_head[`SILO_DATA_BITS-1:0];

	// ======================================================================
	// Receiver active synchronising register
	always @(posedge clk) begin
		if (rst || (ce && receive_clear_pulse)) begin
			rx_active_r <= 1'b0;
		end else if (ce && rx_ctl_tick) begin
			rx_active_r <= rx_decoder_active;
		end
	end

	// ======================================================================
	// Status read paths
	// Write-only and reserved bits read zero; head flags read zero while
	// the silo is empty, so a flushed or never-written entry is not shown
	assign tx_ctl_status = {
		1'b0,
		tx_active_latch_r,
		1'b0,
		tx_in_ready,
		4'h0
	};

	assign rx_ctl_status = {
		1'b0,
		rx_active_r,
		1'b0,
		rx_out_valid,
		rx_head[`SILO_CTL_MSB:`SILO_CTL_LSB] &
			{4{rx_out_valid}}
	};

endmodule // line_unit_silo

`default_nettype wire

// [hw/line_unit_defines.vh]
/*
 * Constants for the line unit silo sequencing and control/status block:
 * register field positions, silo geometry, check residue, clear timing.
 * Assumes it is included by bare name from the design files under hw/.
 */
`ifndef LINE_UNIT_DEFINES_VH
`define LINE_UNIT_DEFINES_VH

// ==========================================================================
// Transmit control/status register fields
`define TXCS_MSG_BEGIN 0
`define TXCS_MSG_FINISH 1
`define TXCS_CTL_LSB 0
`define TXCS_CTL_MSB 3
`define TXCS_IN_READY 4
`define TXCS_ACTIVE 6
`define TXCS_CLEAR 7

// ==========================================================================
// Receive control/status register fields
`define RXCS_MATCH 0
`define RXCS_BLOCK_END 1
`define RXCS_OUT_READY 4
`define RXCS_ACTIVE 6
`define RXCS_CLEAR 7

// ==========================================================================
// Silo geometry: 8 data bits plus 4 control bits per entry
`define SILO_DEPTH 64
`define SILO_WIDTH 12
`define SILO_DATA_BITS 8
`define SILO_CTL_LSB 8
`define SILO_CTL_MSB 11

// ==========================================================================
// Check register residue for a good frame in bit-stuff mode (octal 016417)
`define CHECK_RESIDUE 16'h1D0F
`define CHECK_ZERO 16'h0000

// ==========================================================================
// Clear pulse width: least time, rounded up to whole clock cycles
`define CLEAR_NS 400
`define CLK_NS 8
`define CLEAR_CYCLES ((`CLEAR_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [hw/silo_fifo.v]
/*
 * Parameterised first-in first-out silo with valid/ready on both sides.
 * Assumes one clock, synchronous active-high reset and a clock enable that
 * freezes every flip-flop while low.
 */
`timescale 1ns/100ps
`default_nettype none

module silo_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock, reset, enable
	input wire clk,
	input wire rst,
	input wire ce,
	input wire flush,
	// Filling side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Draining side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	// Full and empty follow the occupancy count exactly
	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage array; no reset needed, reads are guarded by the count
	always @(posedge clk) begin
		if (ce && push)
			mem[wr_ptr_r] <= in_data;
	end

	// Pointers wrap naturally; depth is a power of two
	always @(posedge clk) begin
		if (rst || (ce && flush)) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule // silo_fifo

`default_nettype wire

// [verif/silo_checker_properties.sv]
/* Port checker for line_unit_silo.
   Assumes ce is held high and a bind in the bench top file. */
`timescale 1ns/100ps
`default_nettype none
module silo_checker #(
	parameter CLEAR_CYCLES = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Processor side
	input wire logic [7:0] obus,
	input wire logic sel_tx_data,
	input wire logic sel_tx_ctl,
	input wire logic sel_rx_ctl,
	input wire logic device_clear,
	input wire logic [7:0] tx_ctl_status,
	input wire logic [7:0] rx_ctl_status,
	// Transmitter side
	input wire logic tx_load,
	input wire logic tx_clk_tick,
	input wire logic tx_decoder_active,
	input wire logic [7:0] tx_char,
	input wire logic tx_queue_has_data,
	input wire logic tx_message_begin,
	input wire logic tx_message_finish,
	input wire logic transmit_clear_pulse,
	input wire logic transmit_clear_pulse_n,
	// Receiver side
	input wire logic rx_char_strobe,
	input wire logic rx_input_ready,
	input wire logic receive_clear_pulse,
	input wire logic receive_clear_pulse_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] tcnt_r;
	// ==========================================================
	// Pulse length counter: repetition counts must stay literal
	always @(posedge clk)
		tcnt_r <= (rst || !transmit_clear_pulse) ? 8'h00 : tcnt_r + 8'h01;
	tx_load_path_a:
	assert property (sel_tx_data && tx_ctl_status[4] && !tx_queue_has_data
		&& !transmit_clear_pulse |-> ##[1:3] tx_queue_has_data)
		else $error("char not queued");
	msg_gate_a:
	assert property (!tx_queue_has_data |-> !tx_message_begin
		&& !tx_message_finish) else $error("message bits not gated");
	status_zero_a:
	assert property (tx_ctl_status[7] == 0 && tx_ctl_status[5] == 0
		&& tx_ctl_status[3:0] == 0 && rx_ctl_status[7] == 0
		&& rx_ctl_status[5] == 0 && rx_ctl_status[3:2] == 0)
		else $error("unused status bit set");
	clear_width_a:
	assert property ($fell(transmit_clear_pulse) |-> tcnt_r == CLEAR_CYCLES)
		else $error("clear pulse width wrong");
	clear_pair_a:
	assert property (transmit_clear_pulse_n == !transmit_clear_pulse
		&& receive_clear_pulse_n == !receive_clear_pulse)
		else $error("clear pulses not complementary");
	tx_clear_start_a:
	assert property ((sel_tx_ctl && obus[7]) || device_clear |->
		##[1:2] transmit_clear_pulse) else $error("no transmit clear");
	rx_clear_start_a:
	assert property ((sel_rx_ctl && obus[7]) || device_clear |->
		##[1:2] receive_clear_pulse) else $error("no receive clear");
	rx_flush_a:
	assert property (receive_clear_pulse |-> ##1 !rx_ctl_status[4])
		else $error("receive silo not flushed");
	unload_cause_a:
	assert property ($changed(tx_char) && !transmit_clear_pulse
		&& !$past(transmit_clear_pulse) |->
		$past(tx_load, 2) || $past(tx_load, 3))
		else $error("char changed without load");
	tx_active_a:
	assert property (tx_clk_tick && !transmit_clear_pulse
		##1 !transmit_clear_pulse |->
		tx_ctl_status[6] == $past(tx_decoder_active))
		else $error("active flag not captured");
	rx_arrival_a:
	assert property (rx_char_strobe && rx_input_ready && !rx_ctl_status[4]
		&& !receive_clear_pulse |-> ##[2:3] rx_ctl_status[4])
		else $error("received char not shown");
endmodule // silo_checker
`default_nettype wire

// [verif/tx_far_side.sv]
/* Transmitter stand-in: unloads one char at a time, ticks its clock.
   Assumes it shares clk and rst with the block. */
`timescale 1ns/100ps
`default_nettype none
module tx_far_side (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Silo status and pacing
	input wire logic has_data,
	input wire logic stall,
	output logic load,
	output logic tick,
	output logic active
);
	logic [2:0] gap_r;
	initial begin
		load = 1'b0;
		tick = 1'b0;
		active = 1'b0;
	end
	// One load, then a gap so the unload settles before the next
	always @(posedge clk) begin
		if (rst || gap_r != 3'h0) begin
			load <= 1'b0;
			gap_r <= rst ? 3'h0 : gap_r - 3'h1;
		end else begin
			load <= has_data && !stall;
			gap_r <= (has_data && !stall) ? 3'h4 : 3'h0;
		end
	end
	// Clock ticks every other cycle; active follows the queue
	always @(posedge clk) begin
		tick <= rst ? 1'b0 : !tick;
		active <= has_data;
	end
endmodule // tx_far_side
`default_nettype wire

// [verif/line_unit_silo_tb.sv]
/* Bench for line_unit_silo; transmitter is tx_far_side.
   Assumes a 4-deep silo and a 3-cycle clear in simulation. */
`timescale 1ns/100ps
`default_nettype none
module line_unit_silo_tb;
	localparam CLR = 3;
	logic clk = 0, rst = 1, ce = 1, stall = 1;
	logic [7:0] obus = 0, rx_char = 0, lastc;
	logic [15:0] rx_check = 0;
	logic sel_tx_data = 0, sel_tx_ctl = 0, sel_rx_ctl = 0, device_clear = 0;
	logic rx_read_accepted = 0, rx_char_strobe = 0, rx_ctl_tick = 0;
	logic rx_decoder_active = 0, bit_stuff_mode = 0, primary_mode = 0;
	logic flag_received = 0, message_active = 0, addr_sync_received = 0;
	logic abort_received = 0;
	wire [7:0] tx_ctl_status, rx_ctl_status, rx_data, tx_char;
	wire tx_load, tx_clk_tick, tx_decoder_active, tx_queue_has_data;
	wire tx_message_begin, tx_message_finish, transmit_clear_pulse;
	wire transmit_clear_pulse_n, rx_input_ready, receive_clear_pulse;
	wire receive_clear_pulse_n;
	wire [1:0] msg_bits = {tx_message_finish, tx_message_begin};
	integer seed = 85, err_total = 0, num_checks = 0, cyc = 0, i, t;
	logic [9:0] txq[$];
	logic [9:0] ent, got;
	line_unit_silo #(.SILO_DEPTH(4), .SILO_AW(2), .CLEAR_CYCLES(CLR))
		DUT (
		.clk(clk), .rst(rst), .ce(ce), .obus(obus),
		.sel_tx_data(sel_tx_data), .sel_tx_ctl(sel_tx_ctl),
		.sel_rx_ctl(sel_rx_ctl), .device_clear(device_clear),
		.rx_read_accepted(rx_read_accepted),
		.tx_ctl_status(tx_ctl_status), .rx_ctl_status(rx_ctl_status),
		.rx_data(rx_data), .tx_load(tx_load), .tx_clk_tick(tx_clk_tick),
		.tx_decoder_active(tx_decoder_active), .tx_char(tx_char),
		.tx_queue_has_data(tx_queue_has_data),
		.tx_message_begin(tx_message_begin),
		.tx_message_finish(tx_message_finish),
		.transmit_clear_pulse(transmit_clear_pulse),
		.transmit_clear_pulse_n(transmit_clear_pulse_n),
		.rx_char_strobe(rx_char_strobe), .rx_char(rx_char),
		.rx_check(rx_check), .bit_stuff_mode(bit_stuff_mode),
		.primary_mode(primary_mode), .flag_received(flag_received),
		.message_active(message_active),
		.addr_sync_received(addr_sync_received),
		.abort_received(abort_received), .rx_ctl_tick(rx_ctl_tick),
		.rx_decoder_active(rx_decoder_active),
		.rx_input_ready(rx_input_ready),
		.receive_clear_pulse(receive_clear_pulse),
		.receive_clear_pulse_n(receive_clear_pulse_n));
	tx_far_side far (.clk(clk), .rst(rst), .has_data(tx_queue_has_data),
		.stall(stall), .load(tx_load), .tick(tx_clk_tick),
		.active(tx_decoder_active));
	always #4 clk = !clk;
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// Strobes are one cycle wide with a gap cycle after each
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
		step(1);
	endtask
	task automatic wr(ref logic s, input logic [7:0] v);
		obus = v;
		pulse(s);
	endtask
	// Control bits go in first so they ride with the data
	task automatic txput(input logic [9:0] e);
		wr(sel_tx_ctl, {6'h0, e[9:8]});
		wr(sel_tx_data, e[7:0]);
		step(2);
	endtask
	task automatic rxput(input logic [7:0] c);
		rx_char = c;
		pulse(rx_char_strobe);
	endtask
	// f = {bit_stuff, primary, flag, msg, addr, abort}
	function automatic logic [1:0] exp_flags(input logic [5:0] f,
		input logic [15:0] c);
		logic hit;
		hit = f[5] ? (c == 16'h1D0F) : (c == 16'h0000);
		return {(f[3] && (f[4] ? f[2] : f[1])) || f[0], hit};
	endfunction
	// Each unload must hand over the oldest queued character
	always @(posedge clk) begin
		if (tx_load && tx_queue_has_data) begin
			got = txq.pop_front();
			chk("tx_flags", msg_bits, got[9:8]);
			repeat (2) @(posedge clk);
			#1 chk("tx_char", tx_char, got[7:0]);
		end
	end
	// Cut a hang short; the run needs well under 2000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		step(4);
		rst = 0;
		step(1);
		chk("tx_cs", tx_ctl_status, 8'h10);
		chk("rx_cs", rx_ctl_status, 8'h00);
		// Every mode and flag combination, check value cycling zero, residue, random
		for (i = 0; i < 64; i++) begin
			{bit_stuff_mode, primary_mode, flag_received, message_active,
				addr_sync_received, abort_received} = i[5:0];
			rx_check = (i % 3 == 0) ? 16'h0000 : (i % 3 == 1) ? 16'h1D0F
				: 16'($random(seed));
			rxput(8'($random(seed)));
			step(3);
			chk("rx_data", rx_data, rx_char);
			ent = {2'b00, 6'h04, exp_flags(i[5:0], rx_check)};
			chk("rx_cs", rx_ctl_status, ent[7:0]);
			pulse(rx_read_accepted);
			pulse(rx_read_accepted);
			chk("rx_pop", {rx_ctl_status[4], rx_input_ready}, 1);
		end
		// Fill the transmit silo until it refuses, far side stalled
		for (i = 0; i < 8 && tx_ctl_status[4] === 1'b1; i++) begin
			ent = 10'($random(seed));
			txput(ent);
			txq.push_back(ent);
			chk("tx_head", msg_bits, txq[0][9:8]);
		end
		wr(sel_tx_data, 8'hA5);
		chk("tx_count", txq.size(), 4);
		lastc = txq[3][7:0];
		stall = 0;
		step(40);
		chk("tx_drain", txq.size(), 0);
		chk("tx_hold", tx_char, lastc);
		chk("tx_room", tx_ctl_status, 8'h10);
		// Register clear, then device clear, each with one transmit char queued and a full receive silo
		for (t = 0; t < 2; t++) begin
			stall = 1;
			txput(10'($random(seed)));
			for (i = 0; i < 4; i++)
				rxput(8'($random(seed)));
			step(2);
			chk("tx_act", tx_ctl_status[6], 1);
			chk("rx_full", rx_input_ready, 0);
			if (t == 0) begin
				wr(sel_tx_ctl, 8'h80);
				wr(sel_rx_ctl, 8'h80);
			end else
				pulse(device_clear);
			step(CLR + 2);
			chk("clr", {tx_queue_has_data, rx_ctl_status}, 0);
			chk("rx_room", rx_input_ready, 1);
		end
		for (i = 1; i >= 0; i--) begin
			rx_decoder_active = i[0];
			pulse(rx_ctl_tick);
			chk("rx_act", rx_ctl_status[6], i[0]);
		end
		stop_test();
	end
endmodule // line_unit_silo_tb
bind line_unit_silo silo_checker #(.CLEAR_CYCLES(CLEAR_CYCLES)) chk_i (
	.clk(clk), .rst(rst), .obus(obus), .sel_tx_data(sel_tx_data),
	.sel_tx_ctl(sel_tx_ctl), .sel_rx_ctl(sel_rx_ctl),
	.device_clear(device_clear), .tx_ctl_status(tx_ctl_status),
	.rx_ctl_status(rx_ctl_status), .tx_load(tx_load),
	.tx_clk_tick(tx_clk_tick), .tx_decoder_active(tx_decoder_active),
	.tx_char(tx_char), .tx_queue_has_data(tx_queue_has_data),
	.tx_message_begin(tx_message_begin),
	.tx_message_finish(tx_message_finish),
	.transmit_clear_pulse(transmit_clear_pulse),
	.transmit_clear_pulse_n(transmit_clear_pulse_n),
	.rx_char_strobe(rx_char_strobe), .rx_input_ready(rx_input_ready),
	.receive_clear_pulse(receive_clear_pulse),
	.receive_clear_pulse_n(receive_clear_pulse_n));
`default_nettype wire
